// ### pdm_pkg.sv
// package: register map, reset values and field positions of the port block
package pdm_pkg;
  localparam logic [7:0]  OFF_PIN_VALUE   = 8'h00;
  localparam logic [7:0]  OFF_OUT_LATCH   = 8'h04;
  localparam logic [7:0]  OFF_DIRECTION   = 8'h08;
  localparam logic [7:0]  OFF_OTHER_LATCH = 8'h0C;
  localparam logic [7:0]  OFF_MODE_CTRL   = 8'h10;
  localparam logic [7:0]  RST_OUT_LATCH   = 8'h00;
  localparam logic [7:0]  RST_DIRECTION   = 8'hFF;
  localparam logic [7:0]  RST_OTHER_LATCH = 8'h00;
  localparam logic [3:0]  RST_MODE_CTRL   = 4'h0;
  localparam int          PULLUP_BIT      = 7;
  localparam int          MODE_MEMBUS_BIT = 0;
  localparam int          MODE_PSP_BIT    = 1;
  localparam int          MODE_SPI_BIT    = 2;
  localparam int          MODE_I2C_BIT    = 3;
  localparam int          PIN_SDATA       = 5;
  localparam int          PIN_SCLK        = 6;
  localparam int          PIN_SSEL        = 7;
  localparam logic [7:0]  SMALL_PKG_MASK  = 8'h07;
endpackage : pdm_pkg

// ### pdm_pin_cell.sv
// one pad cell: priority mux of alternate functions over the port latch
`timescale 1ns/1ps
module pdm_pin_cell (
  input  wire logic membus_en,
  input  wire logic membus_out,
  input  wire logic membus_oe,
  input  wire logic psp_en,
  input  wire logic psp_read,
  input  wire logic latch_bit,
  input  wire logic dir_bit,
  input  wire logic alt_en,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  input  wire logic alt_override_dir,
  input  wire logic pullup_ctrl,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup
);
  always_comb begin
    if (membus_en) begin
      pad_out = membus_out;
      pad_oe  = membus_oe;
    end else if (psp_en) begin
      pad_out = latch_bit;
      pad_oe  = psp_read;
    end else if (alt_en && alt_override_dir) begin
      pad_out = alt_out;
      pad_oe  = alt_oe;
    end else if (alt_en && alt_oe) begin
      pad_out = alt_out;
      pad_oe  = 1'b1;
    end else begin
      pad_out = latch_bit;
      pad_oe  = ~dir_bit;
    end
    pad_pullup = pullup_ctrl & ~pad_oe;
  end
endmodule : pdm_pin_cell

// ### pdm_port_top.sv
// top: register file over APB and pin muxing of the upper port pins
// =====================================================================
// Function
// - direction 0 drives latch, 1 is input
// - pull-ups on when other-port latch bit 7 set
// - memory bus overrides all other pin uses
// - memory bus drives/accepts data, ignoring direction
// - parallel port drives latch on read, captures write
// - don't-care functions override the direction bit
// - serial clock driven at dir 0, received at 1
// - serial data input taken from bit five
// - two-wire data driven on bit five, also input
// - two-wire clock driven at dir 0, else received
// - bit seven always feeds slave select input
// - small packages read upper bits as zero
// - pull-up off on any pin driving output
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module pdm_port_top #(
  parameter bit FULL_PACKAGE = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pin_pullup,
  input  wire logic [7:0]  membus_out,
  input  wire logic        membus_oe,
  output logic      [7:0]  membus_in,
  input  wire logic        psp_read,
  input  wire logic        psp_write,
  output logic      [7:0]  psp_data,
  input  wire logic        serial_clock_out,
  input  wire logic        serial_clock_master,
  output logic             serial_clock_line,
  output logic             serial_data_in,
  input  wire logic        twowire_data_drive_low,
  output logic             twowire_data,
  input  wire logic        twowire_clock_drive_low,
  output logic             twowire_clock,
  output logic             serial_slave_select,
  output logic             membus_enable,
  output logic             psp_enable
);
  // =====================================================================
  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // =====================================================================
  // state
  typedef struct packed {
    logic [7:0]  out_latch;
    logic [7:0]  direction;
    logic [7:0]  other_latch;
    logic [3:0]  mode;
    logic [7:0]  psp_data;
    logic [31:0] rdata;
  } pdm_state_s;
  pdm_state_s st_q;
  pdm_state_s st_d;

  logic [7:0] impl_mask;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic [7:0] pad_pu;
  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] pin_seen;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be,
                                             input logic [7:0]  mask);
    merge_byte = (be[0] ? wd[7:0] : old_v) & mask;
  endfunction : merge_byte

  assign impl_mask = FULL_PACKAGE ? 8'hFF : pdm_pkg::SMALL_PKG_MASK;
  assign wr_acc    = psel & penable & pwrite;
  assign rd_acc    = psel & ~penable & ~pwrite;
  assign pin_seen  = pin_in & impl_mask;

  // =====================================================================
  // register file and capture
  always_comb begin
    st_d = st_q;
    if (wr_acc) begin
      unique case (paddr)
        pdm_pkg::OFF_PIN_VALUE,
        pdm_pkg::OFF_OUT_LATCH:
          st_d.out_latch = merge_byte(st_q.out_latch, pwdata, pstrb, impl_mask);
        pdm_pkg::OFF_DIRECTION:
          st_d.direction = merge_byte(st_q.direction, pwdata, pstrb, impl_mask);
        pdm_pkg::OFF_OTHER_LATCH:
          st_d.other_latch = merge_byte(st_q.other_latch, pwdata, pstrb, 8'hFF);
        pdm_pkg::OFF_MODE_CTRL: begin
          if (pstrb[0]) begin
            st_d.mode = pwdata[3:0];
          end
        end
        default: ;
      endcase
    end
    // host write strobe captures pin level as parallel data
    if (psp_enable && psp_write) begin
      st_d.psp_data = pin_seen;
    end
    // read data registered in setup so it is stable during access
    if (rd_acc) begin
      unique case (paddr)
        pdm_pkg::OFF_PIN_VALUE:   st_d.rdata = {24'h000000, pin_seen};
        pdm_pkg::OFF_OUT_LATCH:   st_d.rdata = {24'h000000, st_q.out_latch & impl_mask};
        pdm_pkg::OFF_DIRECTION:   st_d.rdata = {24'h000000, st_q.direction & impl_mask};
        pdm_pkg::OFF_OTHER_LATCH: st_d.rdata = {24'h000000, st_q.other_latch};
        pdm_pkg::OFF_MODE_CTRL:   st_d.rdata = {28'h0000000, st_q.mode};
        default:                  st_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{out_latch:   pdm_pkg::RST_OUT_LATCH,
                direction:   pdm_pkg::RST_DIRECTION,
                other_latch: pdm_pkg::RST_OTHER_LATCH,
                mode:        pdm_pkg::RST_MODE_CTRL,
                psp_data:    8'h00,
                rdata:       32'h00000000};
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // =====================================================================
  // pin muxing
  assign membus_enable = st_q.mode[pdm_pkg::MODE_MEMBUS_BIT];
  // memory bus owns the pins, so the parallel port yields to it
  assign psp_enable    = st_q.mode[pdm_pkg::MODE_PSP_BIT] & ~membus_enable;

  logic [7:0] alt_en;
  logic [7:0] alt_out;
  logic [7:0] alt_oe;
  logic [7:0] alt_ovr;
  logic       spi_on;
  logic       i2c_on;
  assign spi_on = st_q.mode[pdm_pkg::MODE_SPI_BIT];
  assign i2c_on = st_q.mode[pdm_pkg::MODE_I2C_BIT] & ~spi_on;

  always_comb begin
    alt_en  = 8'h00;
    alt_out = 8'h00;
    alt_oe  = 8'h00;
    alt_ovr = 8'h00;
    // clock pin: driven only while direction bit is 0
    alt_en[pdm_pkg::PIN_SCLK]  = spi_on | i2c_on;
    alt_out[pdm_pkg::PIN_SCLK] = spi_on ? serial_clock_out : 1'b0;
    alt_oe[pdm_pkg::PIN_SCLK]  = ~st_q.direction[pdm_pkg::PIN_SCLK] &
                                 (spi_on ? serial_clock_master : twowire_clock_drive_low);
    // open-drain clock: dir 0 must not fall back to driving the latch level
    alt_ovr[pdm_pkg::PIN_SCLK] = i2c_on;
    // two-wire data: open drain low while direction bit is 1
    alt_en[pdm_pkg::PIN_SDATA]  = i2c_on;
    alt_out[pdm_pkg::PIN_SDATA] = 1'b0;
    alt_oe[pdm_pkg::PIN_SDATA]  = i2c_on & st_q.direction[pdm_pkg::PIN_SDATA] &
                                  twowire_data_drive_low;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      pdm_pin_cell u_cell (
        .membus_en        (membus_enable & impl_mask[gi]),
        .membus_out       (membus_out[gi]),
        .membus_oe        (membus_oe),
        .psp_en           (psp_enable & impl_mask[gi]),
        .psp_read         (psp_read),
        .latch_bit        (st_q.out_latch[gi] & impl_mask[gi]),
        .dir_bit          (st_q.direction[gi] | ~impl_mask[gi]),
        .alt_en           (alt_en[gi] & impl_mask[gi]),
        .alt_out          (alt_out[gi]),
        .alt_oe           (alt_oe[gi]),
        .alt_override_dir (alt_ovr[gi]),
        .pullup_ctrl      (st_q.other_latch[pdm_pkg::PULLUP_BIT] & impl_mask[gi]),
        .pad_out          (pad_out[gi]),
        .pad_oe           (pad_oe[gi]),
        .pad_pullup       (pad_pu[gi])
      );
    end
  endgenerate

  assign pin_out    = pad_out;
  assign pin_oe     = pad_oe;
  assign pin_pullup = pad_pu;

  // =====================================================================
  // inputs toward peripherals
  assign membus_in           = pin_seen;
  assign psp_data            = st_q.psp_data;
  assign serial_data_in      = pin_seen[pdm_pkg::PIN_SDATA];
  assign twowire_data        = pin_seen[pdm_pkg::PIN_SDATA];
  assign serial_clock_line   = pin_seen[pdm_pkg::PIN_SCLK];
  assign twowire_clock       = pin_seen[pdm_pkg::PIN_SCLK];
  // select is sampled whatever the direction bit holds
  assign serial_slave_select = pin_seen[pdm_pkg::PIN_SSEL];
endmodule : pdm_port_top

// ### pdm_pad_model.sv
// partner: pad wires joining block drive, outside drivers and pull-ups
`timescale 1ns/1ps
module pdm_pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_oe,
  output logic      [7:0] pin_in
);
  logic [7:0] float_q = 8'h55;
  // undriven pads wander so a stale level never passes as a reading
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_oe[i] ? ext_val[i] : pin_pullup[i] | float_q[i];
    end
  end
endmodule : pdm_pad_model

// ### pdm_port_asserts.sv
// checker: pin mux relations at the port block boundary
`timescale 1ns/1ps
module pdm_port_asserts (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] membus_out,
  input wire logic       membus_oe,
  input wire logic [7:0] membus_in,
  input wire logic       psp_read,
  input wire logic       psp_write,
  input wire logic [7:0] psp_data,
  input wire logic       serial_data_in,
  input wire logic       serial_slave_select,
  input wire logic       membus_enable,
  input wire logic       psp_enable
);
  // ===========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_membus_dir: assert property (membus_enable |-> pin_oe[7:5] == {3{membus_oe}})
    else $error("memory bus direction wrong");
  a_membus_data: assert property (membus_enable && membus_oe |-> pin_out[7:5] == membus_out[7:5])
    else $error("memory bus data not on pads");
  a_membus_in: assert property (membus_enable |-> membus_in[7:5] == pin_in[7:5])
    else $error("memory bus input wrong");
  a_pullup_off: assert property ((pin_oe & pin_pullup) == 8'h00)
    else $error("pull-up on a driven pad");
  a_select_line: assert property (serial_slave_select == pin_in[7])
    else $error("slave select not from pad");
  a_sdata_line: assert property (serial_data_in == pin_in[5])
    else $error("serial data not from pad");
  a_psp_drive: assert property (psp_enable && !membus_enable && psp_read |-> pin_oe[7:5] == 3'h7)
    else $error("host read not driven");
  a_psp_capture: assert property (psp_enable && !membus_enable && psp_write
    |=> {psp_data[7:5], 5'h00} == ($past(pin_in) & 8'hE0))
    else $error("host write not captured");
  a_apb_answer: assert property (psel && penable |-> pready && !pslverr)
    else $error("bus answer wrong");
endmodule : pdm_port_asserts
bind pdm_port_top pdm_port_asserts u_pdm_port_asserts (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .membus_out(membus_out),
  .membus_oe(membus_oe), .membus_in(membus_in), .psp_read(psp_read), .psp_write(psp_write),
  .psp_data(psp_data), .serial_data_in(serial_data_in), .psp_enable(psp_enable),
  .serial_slave_select(serial_slave_select), .membus_enable(membus_enable));

// ### pdm_port_top_tb_top.sv
// testbench: registers, pin muxing and alternate functions of the port block
`timescale 1ns/1ps
module pdm_port_top_tb_top;
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, ext_val = 8'h00, ext_oe = 8'h00, membus_out = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, membus_in, psp_data;
  logic        pready, pslverr, membus_oe = 1'b0, psp_read = 1'b0, psp_write = 1'b0;
  logic        sck_out = 1'b0, sck_master = 1'b0, sda_low = 1'b0, scl_low = 1'b0;
  logic        sck_line, sdi, sda, scl, ssel, mb_en, psp_en;
  int          error_cnt = 0, n_compared = 0;
  always #25 clk = ~clk;
  pdm_port_top u_pdm_port_top (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .membus_out(membus_out), .membus_oe(membus_oe),
    .membus_in(membus_in), .psp_read(psp_read), .psp_write(psp_write), .psp_data(psp_data),
    .serial_clock_out(sck_out), .serial_clock_master(sck_master), .serial_clock_line(sck_line),
    .serial_data_in(sdi), .twowire_data_drive_low(sda_low), .twowire_data(sda),
    .twowire_clock_drive_low(scl_low), .twowire_clock(scl), .serial_slave_select(ssel),
    .membus_enable(mb_en), .psp_enable(psp_en));
  pdm_pad_model u_pdm_pad_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));
  // ===========================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) begin
      error_cnt++;
      conclude();
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // ===========================================
  // scenarios
  task automatic s_reset();
    logic [7:0] offs [4] = '{pdm_pkg::OFF_OUT_LATCH, pdm_pkg::OFF_OTHER_LATCH,
                             pdm_pkg::OFF_MODE_CTRL, 8'h14};
    chk("reset oe", pin_oe, 32'h0);
    apb(1'b0, pdm_pkg::OFF_DIRECTION, 32'h0);
    chk("dir reset", rd, 32'hFF);
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk("zero reset", rd, 32'h0);
    end
  endtask : s_reset
  task automatic s_port();
    apb(1'b1, pdm_pkg::OFF_DIRECTION, 32'h1F);
    apb(1'b1, pdm_pkg::OFF_OUT_LATCH, 32'hA0);
    #1;
    chk("port drive", {pin_oe[7:5], pin_out[7:5]}, 32'h3D);
    apb(1'b1, pdm_pkg::OFF_DIRECTION, 32'hFF);
    apb(1'b1, pdm_pkg::OFF_OTHER_LATCH, 32'h80);
    ext_oe <= 8'h20;
    #1;
    chk("pullups", pin_pullup[7:5], 32'h7);
    apb(1'b0, pdm_pkg::OFF_PIN_VALUE, 32'h0);
    chk("pin read", rd & 32'hE0, 32'hC0);
    apb(1'b1, pdm_pkg::OFF_DIRECTION, 32'h1F);
    #1;
    chk("pullup off", pin_pullup[7:5], 32'h0);
  endtask : s_port
  task automatic s_membus();
    ext_oe <= 8'h00;
    apb(1'b1, pdm_pkg::OFF_MODE_CTRL, 32'h3);
    psp_read   <= 1'b1;
    membus_out <= 8'h40;
    membus_oe  <= 1'b1;
    @(posedge clk);
    #1;
    chk("membus drive", {pin_oe[7:5], pin_out[7:5]}, 32'h3A);
    chk("membus mode", {mb_en, psp_en}, 32'h2);
    membus_oe <= 1'b0;
    ext_oe    <= 8'hFF;
    ext_val   <= 8'hA0;
    @(posedge clk);
    #1;
    chk("membus in", {pin_oe[7:5], membus_in[7:5]}, 32'h05);
  endtask : s_membus
  task automatic s_psp();
    ext_oe <= 8'h00;
    apb(1'b1, pdm_pkg::OFF_MODE_CTRL, 32'h2);
    apb(1'b1, pdm_pkg::OFF_OUT_LATCH, 32'hE0);
    apb(1'b1, pdm_pkg::OFF_DIRECTION, 32'hFF);
    #1;
    chk("host read", {pin_oe[7:5], pin_out[7:5]}, 32'h3F);
    chk("psp mode", {mb_en, psp_en}, 32'h1);
    psp_read <= 1'b0;
    ext_oe   <= 8'hFF;
    ext_val  <= 8'h60;
    @(posedge clk);
    psp_write <= 1'b1;
    @(posedge clk);
    psp_write <= 1'b0;
    @(posedge clk);
    #1;
    chk("host write", psp_data[7:5], 32'h3);
  endtask : s_psp
  task automatic s_serial();
    ext_oe <= 8'h20;
    ext_val <= 8'h00;
    apb(1'b1, pdm_pkg::OFF_MODE_CTRL, 32'h4);
    apb(1'b1, pdm_pkg::OFF_DIRECTION, 32'h3F);
    sck_master <= 1'b1;
    sck_out    <= 1'b1;
    @(posedge clk);
    #1;
    chk("spi master", {pin_oe[6], pin_out[6], sdi, ssel}, 32'hD);
    apb(1'b1, pdm_pkg::OFF_DIRECTION, 32'hFF);
    sck_master <= 1'b0;
    ext_oe     <= 8'hE0;
    ext_val    <= 8'h40;
    @(posedge clk);
    #1;
    chk("spi slave", {pin_oe[6], sck_line, sdi, ssel}, 32'h4);
    ext_oe <= 8'h00;
    apb(1'b1, pdm_pkg::OFF_MODE_CTRL, 32'h8);
    apb(1'b1, pdm_pkg::OFF_DIRECTION, 32'hBF);
    sda_low <= 1'b1;
    scl_low <= 1'b1;
    @(posedge clk);
    #1;
    chk("twowire low", {pin_oe[6:5], pin_out[6:5], sda, scl}, 32'h30);
    sda_low <= 1'b0;
    scl_low <= 1'b0;
    @(posedge clk);
    #1;
    chk("twowire free", {pin_oe[6:5], sda, scl}, 32'h3);
  endtask : s_serial
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    s_reset();
    s_port();
    s_membus();
    s_psp();
    s_serial();
    conclude();
  end
endmodule : pdm_port_top_tb_top
